//--- design/imrc_pkg.sv
// constants, field positions and state type of the two-wire bus master register block
package imrc_pkg;

  // ==========================================================================
  // register indices (byte address = index * 4)
  localparam logic [2:0]  IDX_DIV_LO   = 3'h0;
  localparam logic [2:0]  IDX_DIV_HI   = 3'h1;
  localparam logic [2:0]  IDX_CONTROL  = 3'h2;
  localparam logic [2:0]  IDX_DATA     = 3'h3;  // write: tx_byte, read: rx_byte
  localparam logic [2:0]  IDX_CMD      = 3'h4;  // write: bus_command, read: bus_status
  localparam int          ADDR_LSB     = 2;
  localparam int          ADDR_MSB     = 4;

  // ==========================================================================
  // field positions
  localparam int          CTRL_CORE_ON = 7;
  localparam int          CTRL_IRQ_ON  = 6;
  localparam int          CMD_START    = 7;
  localparam int          CMD_STOP     = 6;
  localparam int          CMD_READ     = 5;
  localparam int          CMD_WRITE    = 4;
  localparam int          CMD_ACK      = 3;
  localparam int          CMD_IRQ_CLR  = 0;
  localparam int          ST_NACK      = 7;
  localparam int          ST_BUSY      = 6;
  localparam int          ST_ARB_LOST  = 5;
  localparam int          ST_XFER      = 1;
  localparam int          ST_IRQ       = 0;

  // ==========================================================================
  // reset values and sequencing counts
  localparam logic [15:0] DIVIDER_RESET = 16'hffff;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;
  localparam logic [2:0]  PHASE_SAMPLE  = 3'h3;  // waits here for the clock line high
  localparam logic [2:0]  PHASE_LAST    = 3'h4;  // five pieces per bit
  localparam logic [2:0]  BIT_LAST      = 3'h7;

  typedef enum logic [2:0] {
    st_idle,
    st_start,
    st_data,
    st_ack,
    st_stop
  } imrc_state_type;

endpackage : imrc_pkg

//--- design/imrc_top.sv
// two-wire bus master: AHB-Lite register file, byte and bit sequencer, open-drain pins
// Operation
// - control bit 7 enables the core, resets zero, read and write
// - control bit 6 enables the interrupt output; bits 5:0 reserved
// - commands other than interrupt clear accepted only while enabled; pending commands still complete
// - transmit bit 0 is data lsb, or direction bit in address byte
// - receive register holds last received byte, resets to zero
// - command bit 7 requests start or repeated start
// - command bit 6 requests a stop condition
// - command bit 3 picks ack zero or nack one when receiving
// - command bit 0 clears the pending interrupt flag
// - start, stop, read, write, clear command bits self-clear after acting
// - those command bits always read back as zero; reads there return status, where bits 7, 6, 5, 1 and 0 can be one
// - status bit 7 is one when the slave gave no acknowledge
// - status bit 6 set by start seen on bus, cleared by stop
// - status bit 5 set on unrequested stop or data line overridden low
// - status bit 1 is one while a byte transfer is underway
// - status bit 0 set on byte done or arbitration lost; gated interrupt
// - reserved bits read as zero; software writes zeros
// - write sends the transmit byte; read receives a byte into receive register
// - start emitted only with read or write; start or repeated from clock line
`timescale 1ns/1ns

module imrc_top
  import imrc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             irq
);

  // ==========================================================================
  // register state
  logic [15:0]    clock_divider;
  logic           core_on;
  logic           irq_on;
  logic [7:0]     tx_byte;
  logic [7:0]     rx_byte;
  logic           cmd_start_cond;
  logic           cmd_stop_cond;
  logic           cmd_read;
  logic           cmd_write;
  logic           cmd_nack;
  logic           slave_nack_seen;
  logic           bus_busy;
  logic           arb_lost;
  logic           xfer_active;
  logic           irq_flag;

  // bus phase capture
  logic           ph_valid;
  logic           ph_write;
  logic           ph_mapped;
  logic [2:0]     ph_index;
  logic           reg_write;
  logic           take;

  // pin synchronisers and line events
  logic           scl_meta;
  logic           scl_sync;
  logic           sda_meta;
  logic           sda_sync;
  logic           sda_prev;
  logic           start_seen;
  logic           stop_seen;

  // sequencer
  imrc_state_type state;
  logic [2:0]     phase;
  logic [2:0]     bit_cnt;
  logic [7:0]     shifter;
  logic [15:0]    div_cnt;
  logic           tick;
  logic           step;
  logic           arb_event;
  logic           cmd_done;
  logic           byte_done;

  // ==========================================================================
  // AHB-Lite slave: writes land in the data phase, reads take one wait state
  assign take      = hready & hsel & htrans[1];
  assign reg_write = ph_valid & ph_write & ph_mapped;

  // address phase capture
  always_ff @(posedge clock) begin
    if (reset) begin
      ph_valid  <= 1'b0;
      ph_write  <= 1'b0;
      ph_mapped <= 1'b0;
      ph_index  <= 3'h0;
    end else if (hready) begin
      ph_valid  <= take;
      ph_write  <= hwrite;
      ph_mapped <= (haddr[31:ADDR_MSB+1] == '0) && (haddr[ADDR_MSB:ADDR_LSB] <= IDX_CMD);
      ph_index  <= haddr[ADDR_MSB:ADDR_LSB];
    end
  end

  // wait state lets a read see a write that landed one cycle earlier
  always_ff @(posedge clock) begin
    if (reset) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= !(take && !hwrite);
    end
  end

  // read mux, sampled during the wait state; unmapped reads return zero
  always_ff @(posedge clock) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (!hreadyout) begin
      hrdata <= 32'h0000_0000;
      if (ph_mapped) begin
        case (ph_index)
          IDX_DIV_LO:  hrdata[7:0] <= clock_divider[7:0];
          IDX_DIV_HI:  hrdata[7:0] <= clock_divider[15:8];
          IDX_CONTROL: hrdata[7:0] <= {core_on, irq_on, 6'h00};
          IDX_DATA:    hrdata[7:0] <= rx_byte;
          IDX_CMD:     hrdata[7:0] <= {slave_nack_seen, bus_busy, arb_lost, 3'h0,
                                       xfer_active, irq_flag};
          default:     hrdata[7:0] <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================================
  // software-written registers
  always_ff @(posedge clock) begin
    if (reset) begin
      clock_divider <= DIVIDER_RESET;
      core_on       <= 1'b0;
      irq_on        <= 1'b0;
      tx_byte       <= BYTE_RESET;
    end else if (reg_write) begin
      case (ph_index)
        IDX_DIV_LO:  clock_divider[7:0]  <= hwdata[7:0];
        IDX_DIV_HI:  clock_divider[15:8] <= hwdata[7:0];
        IDX_CONTROL: begin
          core_on <= hwdata[CTRL_CORE_ON];
          irq_on  <= hwdata[CTRL_IRQ_ON];
        end
        IDX_DATA:    tx_byte <= hwdata[7:0];
        default:     ;
      endcase
    end
  end

  // command bits: latched only while enabled; all but cmd_nack dropped once acted on
  always_ff @(posedge clock) begin
    if (reset) begin
      cmd_start_cond <= 1'b0;
      cmd_stop_cond  <= 1'b0;
      cmd_read       <= 1'b0;
      cmd_write      <= 1'b0;
      cmd_nack       <= 1'b0;
    end else if (reg_write && ph_index == IDX_CMD && core_on) begin
      cmd_start_cond <= hwdata[CMD_START];
      cmd_stop_cond  <= hwdata[CMD_STOP];
      cmd_read       <= hwdata[CMD_READ];
      cmd_write      <= hwdata[CMD_WRITE];
      cmd_nack       <= hwdata[CMD_ACK];
    end else if (cmd_done || arb_event) begin
      cmd_start_cond <= 1'b0;
      cmd_stop_cond  <= 1'b0;
      cmd_read       <= 1'b0;
      cmd_write      <= 1'b0;
    end
  end

  // ==========================================================================
  // pin synchronisers; edge detection reads only the second stage onward
  always_ff @(posedge clock) begin
    if (reset) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  assign start_seen = scl_sync & sda_prev & !sda_sync;
  assign stop_seen  = scl_sync & !sda_prev & sda_sync;

  // bus occupancy follows any master's start and stop
  always_ff @(posedge clock) begin
    if (reset) begin
      bus_busy <= 1'b0;
    end else if (start_seen) begin
      bus_busy <= 1'b1;
    end else if (stop_seen) begin
      bus_busy <= 1'b0;
    end
  end

  // ==========================================================================
  // divider: one tick per fifth of a serial clock period
  assign tick = (div_cnt == 16'h0000);

  always_ff @(posedge clock) begin
    if (reset) begin
      div_cnt <= DIVIDER_RESET;
    end else if (tick || state == st_idle) begin  // idle reload: a new divider counts at once
      div_cnt <= clock_divider;
    end else begin
      div_cnt <= div_cnt - 16'h0001;
    end
  end

  // a slave stretching the clock holds the sample phase
  assign step = tick && !(phase == PHASE_SAMPLE && !scl_sync);

  // lost arbitration: a stop we did not make, or our released data line read low
  assign arb_event = (state != st_idle && state != st_stop && stop_seen) ||
                     (step && phase == PHASE_SAMPLE && state == st_data &&
                      cmd_write && !sda_oe && !sda_sync);

  // ==========================================================================
  // byte and bit sequencer
  always_ff @(posedge clock) begin
    if (reset) begin
      state           <= st_idle;
      phase           <= 3'h0;
      bit_cnt         <= 3'h0;
      shifter         <= BYTE_RESET;
      rx_byte         <= BYTE_RESET;
      slave_nack_seen <= 1'b0;
      scl_oe          <= 1'b0;
      sda_oe          <= 1'b0;
      cmd_done        <= 1'b0;
      byte_done       <= 1'b0;
    end else begin
      cmd_done  <= 1'b0;
      byte_done <= 1'b0;
      if (arb_event) begin
        // let go of both lines at once; the other master owns the bus now
        state  <= st_idle;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
      end else if (state == st_idle) begin
        phase   <= 3'h0;
        bit_cnt <= 3'h0;
        shifter <= tx_byte;
        // pending commands run even if the core was disabled meanwhile
        if (!cmd_done && (cmd_read || cmd_write)) begin  // finished bits linger one cycle
          state <= cmd_start_cond ? st_start : st_data;
        end else if (!cmd_done && cmd_stop_cond) begin
          state <= st_stop;
        end
      end else if (step) begin
        phase <= (phase == PHASE_LAST) ? 3'h0 : phase + 3'h1;
        case (state)
          // sda released first, so a low clock line gives a repeated start
          st_start: begin
            case (phase)
              3'h0:    sda_oe <= 1'b0;
              3'h2:    scl_oe <= 1'b0;
              3'h3:    sda_oe <= 1'b1;
              3'h4: begin
                scl_oe <= 1'b1;
                state  <= st_data;
              end
              default: ;
            endcase
          end
          st_data: begin
            case (phase)
              3'h0:    scl_oe <= 1'b1;
              3'h1:    sda_oe <= cmd_write & !shifter[7];
              3'h2:    scl_oe <= 1'b0;
              3'h3:    shifter <= {shifter[6:0], sda_sync};
              3'h4: begin
                scl_oe  <= 1'b1;
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == BIT_LAST) begin
                  state <= st_ack;
                  if (cmd_read) begin
                    rx_byte <= shifter;
                  end
                end
              end
              default: ;
            endcase
          end
          st_ack: begin
            case (phase)
              3'h0:    scl_oe <= 1'b1;
              3'h1:    sda_oe <= cmd_read & !cmd_nack;
              3'h2:    scl_oe <= 1'b0;
              3'h3: begin
                if (cmd_write) begin
                  slave_nack_seen <= sda_sync;
                end
              end
              3'h4: begin
                scl_oe <= 1'b1;  // sda kept: no data edge while the clock falls
                if (cmd_stop_cond) begin
                  state <= st_stop;
                end else begin
                  state     <= st_idle;
                  cmd_done  <= 1'b1;
                  byte_done <= 1'b1;
                end
              end
              default: ;
            endcase
          end
          st_stop: begin
            case (phase)
              3'h0:    scl_oe <= 1'b1;
              3'h1:    sda_oe <= 1'b1;
              3'h2:    scl_oe <= 1'b0;
              3'h3:    sda_oe <= 1'b0;
              3'h4: begin
                state     <= st_idle;
                cmd_done  <= 1'b1;
                byte_done <= cmd_read | cmd_write;
              end
              default: ;
            endcase
          end
          default: state <= st_idle;
        endcase
      end
    end
  end

  // fixed outputs: okay response; open-drain pins only ever pull low
  always_ff @(posedge clock) begin
    hresp   <= 1'b0;
    scl_out <= 1'b0;
    sda_out <= 1'b0;
  end

  // ==========================================================================
  // status flags and interrupt
  always_ff @(posedge clock) begin
    xfer_active <= !reset && (state != st_idle);
  end

  // cleared when software asks for a new start
  always_ff @(posedge clock) begin
    if (reset) begin
      arb_lost <= 1'b0;
    end else if (arb_event) begin
      arb_lost <= 1'b1;
    end else if (state == st_idle && cmd_start_cond && (cmd_read || cmd_write)) begin
      arb_lost <= 1'b0;
    end
  end

  // set beats a clear arriving in the same cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      irq_flag <= 1'b0;
    end else if (byte_done || arb_event) begin
      irq_flag <= 1'b1;
    end else if (reg_write && ph_index == IDX_CMD && hwdata[CMD_IRQ_CLR]) begin
      irq_flag <= 1'b0;
    end
  end

  // request pin gated by the enable bit
  always_ff @(posedge clock) begin
    irq <= !reset && irq_flag && irq_on;
  end

endmodule : imrc_top

//--- dv/imrc_properties.sv
// concurrent checks on register bus, pins and interrupt of the bus master
`timescale 1ns/1ns

module imrc_properties
  import imrc_pkg::*;
(
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        scl_in,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        irq
);
  import imrc_pkg::*;
  logic       wr_ph;
  logic [2:0] wr_idx;
  logic       ien_q;
  logic       ever_on;
  logic       clr_wr;
  logic       take;

  assign take = hsel && hready && htrans[1];
  assign clr_wr = wr_ph && wr_idx == IDX_CMD && hwdata[CMD_IRQ_CLR];

  // shadow of control bits, updated where the write lands
  always_ff @(posedge clock) begin
    if (reset) begin
      wr_ph   <= 1'b0;
      wr_idx  <= 3'h0;
      ien_q   <= 1'b0;
      ever_on <= 1'b0;
    end else begin
      wr_ph  <= take && hwrite && haddr[31:5] == 27'h0;
      wr_idx <= haddr[ADDR_MSB:ADDR_LSB];
      if (wr_ph && wr_idx == IDX_CONTROL) begin
        ien_q   <= hwdata[CTRL_IRQ_ON];
        ever_on <= ever_on | hwdata[CTRL_CORE_ON];
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // ==========================================================================
  // assertions
  a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_upper_zero: assert property (hreadyout |-> hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_read_stand: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved");
  a_pins_low: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("pin drives high");
  a_core_off: assert property (!ever_on |-> !scl_oe && !sda_oe)
    else $error("bus driven while never enabled");
  a_irq_gated: assert property (!ien_q && !$past(ien_q) |-> !irq)
    else $error("irq while disabled");
  a_irq_hold: assert property (irq && ien_q && !clr_wr && !$past(clr_wr) |=> irq)
    else $error("irq dropped without clear");

  c_read: cover property (take && !hwrite);
  c_irq: cover property ($rose(irq));
  c_scl: cover property ($rose(scl_oe));
endmodule : imrc_properties

bind imrc_top imrc_properties imrc_properties_inst (
  .clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .irq(irq)
);

//--- dv/imrc_slave_model.sv
// behavioural slave on the two-wire bus: acks bytes, returns a fixed byte
`timescale 1ns/1ns

module imrc_slave_model #(
  parameter logic [7:0] RD_BYTE = 8'h5a
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       nack_on,
  input  wire logic       stretch,
  output logic            sda_pull,
  output logic            scl_pull,
  output logic      [7:0] got_byte,
  output logic            got_ack
);
  logic [7:0] sh;
  logic       rd;
  logic       first;
  int         cnt;

  initial begin
    sda_pull = 1'b0;
    scl_pull = 1'b0;
    got_byte = 8'h00;
    got_ack  = 1'b0;
    sh       = 8'h00;
    rd       = 1'b0;
    first    = 1'b0;
    cnt      = 0;
  end

  // start and stop seen as data edges while the clock is high
  always @(negedge sda) if (scl) begin
    cnt   = 0;
    first = 1'b1;
  end
  always @(posedge sda) if (scl) begin
    cnt = 0;
    rd  = 1'b0;
  end

  // sample on rising clock; ninth bit is the acknowledge
  always @(posedge scl) begin
    if (cnt < 8) sh = {sh[6:0], sda};
    if (cnt == 7) got_byte = sh;
    if (cnt == 8) got_ack = sda;
    cnt++;
  end

  // change data only while the clock is low, optionally stretching it
  always @(negedge scl) begin
    if (cnt == 8) sda_pull = !rd && !nack_on;
    else begin
      if (cnt == 9) begin
        cnt = 0;
        if (first) rd = sh[0];
        else if (got_ack) rd = 1'b0;
        first = 1'b0;
      end
      sda_pull = rd && !RD_BYTE[7 - cnt];
    end
    if (stretch) begin
      scl_pull = 1'b1;
      #300;
      scl_pull = 1'b0;
    end
  end
endmodule : imrc_slave_model

//--- dv/imrc_top_tb.sv
// self-checking bench: register accesses over AHB-Lite against a bus slave model
`timescale 1ns/1ns

module imrc_top_tb;
  import imrc_pkg::*;
  logic        clock, reset, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        scl_oe, sda_oe, irq, sda_pull, scl_pull, jam, nack_on, stretch;
  logic [7:0]  got_byte;
  logic        got_ack, scl, sda;
  int          fail_count, num_checks, cycles;

  // wired-and lines with pull-ups
  assign scl = !(scl_oe || scl_pull);
  assign sda = !(sda_oe || sda_pull || jam);

  imrc_top imrc_top_inst (
    .clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .scl_in(scl),
    .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .irq(irq)
  );
  imrc_slave_model imrc_slave_model_inst (
    .scl(scl), .sda(sda), .nack_on(nack_on), .stretch(stretch), .sda_pull(sda_pull),
    .scl_pull(scl_pull), .got_byte(got_byte), .got_ack(got_ack)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // hang guard: a full run needs well under this many cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one single transfer; held until hready is sampled high
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    bus(1'b1, {27'h0, i, 2'h0}, {24'h0, d});
  endtask : wr

  task automatic chk(input logic [2:0] i, input logic [7:0] e);
    bus(1'b0, {27'h0, i, 2'h0}, 32'h0);
    check(q, {24'h0, e});
  endtask : chk

  // transfer must show as active, then poll until it ends
  task automatic settle;
    repeat (3) @(posedge clock);
    bus(1'b0, {27'h0, IDX_CMD, 2'h0}, 32'h0);
    check({31'h0, q[ST_XFER]}, 32'h1);
    do bus(1'b0, {27'h0, IDX_CMD, 2'h0}, 32'h0); while (q[ST_XFER] !== 1'b0);
    repeat (3) @(posedge clock);
  endtask : settle

  task automatic go(input logic [7:0] c);
    wr(IDX_CMD, c);
    settle();
  endtask : go

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  initial begin
    {hsel, hwrite, jam, nack_on, stretch} = 5'h0;
    {haddr, hwdata, htrans, cycles, fail_count, num_checks} = 0;
    hsize = 3'h2;
    reset = 1'b1;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    chk(IDX_DIV_LO, 8'hff);
    chk(IDX_DIV_HI, 8'hff);
    chk(IDX_CONTROL, 8'h00);
    chk(IDX_DATA, 8'h00);
    wr(IDX_CONTROL, 8'h3f);
    chk(IDX_CONTROL, 8'h00);
    bus(1'b1, 32'h14, 32'hff);
    bus(1'b0, 32'h14, 32'h0);
    check(q, 32'h0);
    wr(IDX_DATA, 8'ha4);
    wr(IDX_CMD, 8'h90);
    repeat (20) @(posedge clock);
    chk(IDX_CMD, 8'h00);
    $display("test reset_and_disabled done");
    wr(IDX_DIV_LO, 8'h01);
    wr(IDX_DIV_HI, 8'h00);
    chk(IDX_DIV_LO, 8'h01);
    wr(IDX_CONTROL, 8'hc0);
    chk(IDX_CONTROL, 8'hc0);
    go(8'h90);
    check(got_byte, 8'ha4);
    chk(IDX_CMD, 8'h41);
    repeat (30) @(posedge clock);
    check(irq, 1'b1);
    wr(IDX_CMD, 8'h01);
    repeat (3) @(posedge clock);
    check(irq, 1'b0);
    chk(IDX_CMD, 8'h40);
    $display("test address_write done");
    wr(IDX_DATA, 8'ha5);
    go(8'h90);
    check(got_byte, 8'ha5);
    wr(IDX_CMD, 8'h01);
    for (int k = 0; k < 2; k++) begin
      go(k[0] ? 8'h28 : 8'h20);
      check(got_ack, k[0]);
      chk(IDX_DATA, 8'h5a);
      wr(IDX_CMD, 8'h01);
    end
    go(8'h40);
    chk(IDX_CMD, 8'h00);
    $display("test read_ack done");
    nack_on <= 1'b1;
    stretch <= 1'b1;
    wr(IDX_DATA, 8'ha6);
    wr(IDX_CMD, 8'hd0);
    wr(IDX_CONTROL, 8'h40);
    settle();
    check(got_byte, 8'ha6);
    chk(IDX_CMD, 8'h81);
    check({scl, sda}, 2'h3);
    $display("test pending_stop done");
    nack_on <= 1'b0;
    stretch <= 1'b0;
    wr(IDX_CONTROL, 8'hc0);
    wr(IDX_CMD, 8'h01);
    wr(IDX_DATA, 8'hff);
    wr(IDX_CMD, 8'h90);
    @(negedge scl);
    @(posedge clock);
    jam <= 1'b1;
    do bus(1'b0, {27'h0, IDX_CMD, 2'h0}, 32'h0); while (q[ST_XFER] !== 1'b0);
    repeat (3) @(posedge clock);
    bus(1'b0, {27'h0, IDX_CMD, 2'h0}, 32'h0);
    check({q[ST_ARB_LOST], q[ST_IRQ]}, 2'h3);
    jam <= 1'b0;
    $display("test arbitration done");
    stop_test();
  end
endmodule : imrc_top_tb
